// ---- rtl/byte_rotator.sv ----
`timescale 1ns/1ps
module byte_rotator
  import ext_byte_op_pkg::*;
(
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              carry_in,
  input  wire logic              dir_right,
  input  wire logic              through_carry,
  output logic      [DATA_W-1:0] result,
  output logic                   carry_out
);

  // ****************************************
  // One-place rotate, plain or through carry
  // ****************************************
  logic fill_left;
  logic fill_right;

  always_comb begin
    fill_left  = through_carry ? carry_in : operand[DATA_W-1];
    fill_right = through_carry ? carry_in : operand[0];
    if (dir_right) begin
      result    = {fill_right, operand[DATA_W-1:1]};
      carry_out = operand[0];
    end else begin
      result    = {operand[DATA_W-2:0], fill_left};
      carry_out = operand[DATA_W-1];
    end
  end

endmodule

// ---- rtl/byte_subtractor.sv ----
`timescale 1ns/1ps
module byte_subtractor
  import ext_byte_op_pkg::*;
(
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  input  wire logic              use_borrow,
  input  wire flags_t            flags_in,
  output logic      [DATA_W-1:0] diff,
  output flags_t                 flags_out
);

  // ****************************************
  // Difference and flags
  // ****************************************
  logic            borrow;
  logic [DATA_W:0] wide;
  logic [NIBBLE_W:0] low;

  always_comb begin
    borrow = use_borrow & ~flags_in.c;
    wide   = {1'b0, minuend} - {1'b0, subtrahend}
             - {{DATA_W{1'b0}}, borrow};
    low    = {1'b0, minuend[NIBBLE_W-1:0]}
             - {1'b0, subtrahend[NIBBLE_W-1:0]}
             - {{NIBBLE_W{1'b0}}, borrow};
    diff   = wide[DATA_W-1:0];
    flags_out.c  = ~wide[DATA_W];
    flags_out.ac = ~low[NIBBLE_W];
    flags_out.z  = (wide[DATA_W-1:0] == BYTE_ZERO);
    flags_out.ov = (minuend[DATA_W-1] ^ subtrahend[DATA_W-1])
                   & (minuend[DATA_W-1] ^ wide[DATA_W-1]);
    flags_out.sc = flags_out.ov ^ wide[DATA_W-1];
    // Chained zero for multi-byte subtracts
    flags_out.cz = use_borrow ? (flags_out.z & flags_in.cz)
                              : flags_out.z;
  end

endmodule

// ---- rtl/ext_byte_op_pkg.sv ----
package ext_byte_op_pkg;

  // ****************************************
  // Widths and constants
  // ****************************************
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 12;
  localparam int BIT_W    = 3;
  localparam int NIBBLE_W = 4;

  localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ZERO     = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE      = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET    = 12'h000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    OP_ROTATE_LEFT_MEM          = 5'h00,
    OP_ROTATE_LEFT_TO_ACC       = 5'h01,
    OP_ROTATE_LEFT_CARRY_MEM    = 5'h02,
    OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h03,
    OP_ROTATE_RIGHT_MEM         = 5'h04,
    OP_ROTATE_RIGHT_TO_ACC      = 5'h05,
    OP_ROTATE_RIGHT_CARRY_MEM   = 5'h06,
    OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h07,
    OP_SUBTRACT_BORROW_TO_ACC   = 5'h08,
    OP_SUBTRACT_BORROW_TO_MEM   = 5'h09,
    OP_SUBTRACT_TO_ACC          = 5'h0a,
    OP_SUBTRACT_TO_MEM          = 5'h0b,
    OP_DECREMENT_SKIP_ZERO      = 5'h0c,
    OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h0d,
    OP_INCREMENT_SKIP_ZERO      = 5'h0e,
    OP_INCREMENT_SKIP_ZERO_TO_ACC = 5'h0f,
    OP_SET_BYTE                 = 5'h10,
    OP_SET_BIT                  = 5'h11,
    OP_SKIP_IF_NONZERO_BYTE     = 5'h12,
    OP_SKIP_IF_NONZERO_BIT      = 5'h13,
    OP_NIBBLE_SWAP_MEM          = 5'h14,
    OP_NIBBLE_SWAP_TO_ACC       = 5'h15
  } op_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
    logic sc;
    logic cz;
  } flags_t;

  typedef struct packed {
    op_t              op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0]  bit_sel;
  } request_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10,
    ST_DUMMY = 2'b11
  } state_t;

  localparam flags_t   FLAGS_RESET   = '0;
  localparam request_t REQUEST_RESET = '0;

endpackage

// ---- rtl/extended_byte_op_datapath.sv ----
// Notes on behaviour
// - Operand address is full width, reaching any data memory section.
// - Rotate left moves bit 7 into bit 0, flags unchanged.
// - Accumulator rotate variants write accumulator (and carry when through carry), memory untouched.
// - Rotate left through carry: carry into bit 0, bit 7 into carry.
// - Rotate right moves bit 0 into bit 7, flags unchanged.
// - Rotate right through carry: carry into bit 7, bit 0 into carry.
// - Borrow subtract is accumulator minus operand minus inverted carry.
// - Subtraction clears carry on negative result, sets it otherwise.
// - Subtracts set overflow, zero, aux, carry, compare, chain-zero flags.
// - Plain subtract uses no borrow; accumulator form writes accumulator.
// - Memory subtract forms write the difference back to memory.
// - Decrement-skip writes memory byte less one, skips on zero, no flags.
// - Increment-skip writes memory byte plus one, skips on zero, no flags.
// - Accumulator step-and-skip forms write accumulator and test it.
// - A taken skip adds one dummy cycle, three cycles in total.
// - Byte set writes all ones to memory, flags unchanged.
// - Bit set forces only the selected bit high, no flags.
// - Bit skip-if-nonzero skips when the selected bit is one.
// - Byte skip-if-nonzero skips when the whole byte is nonzero.
// - Nibble swap exchanges byte halves, no flags.
//
// Implementation choices: the strobed register port.
`timescale 1ns/1ps
module extended_byte_op_datapath
  import ext_byte_op_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire request_t          request,
  input  wire logic [DATA_W-1:0] accumulator_in,
  input  wire flags_t            flags_in,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  output logic                   busy,
  output logic                   mem_rd_en,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_wr_en,
  output logic      [DATA_W-1:0] mem_wr_data,
  output logic                   acc_wr_en,
  output logic      [DATA_W-1:0] acc_wr_data,
  output logic                   flags_wr_en,
  output flags_t                 flags_wr,
  output logic                   skip_next,
  output logic                   dummy_slot,
  output logic                   done
);
  default disable iff (!rst_n);

  // ****************************************
  // Captured request
  // ****************************************
  state_t            state;
  state_t            next_state;
  request_t          req_q;
  logic [DATA_W-1:0] acc_q;
  flags_t            flags_q;
  logic [DATA_W-1:0] operand_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q   <= REQUEST_RESET;
      acc_q   <= BYTE_ZERO;
      flags_q <= FLAGS_RESET;
    end else if (start && state == ST_IDLE) begin
      req_q   <= request;
      acc_q   <= accumulator_in;
      flags_q <= flags_in;
    end
  end

  // Operand as seen in the execute cycle, kept for checking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_q <= BYTE_ZERO;
    end else if (state == ST_EXEC) begin
      operand_q <= mem_rd_data;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  logic next_skip;

  always_comb begin
    case (state)
      ST_IDLE:  next_state = start ? ST_FETCH : ST_IDLE;
      ST_FETCH: next_state = ST_EXEC;
      ST_EXEC:  next_state = next_skip ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Arithmetic units
  // ****************************************
  logic              rot_right;
  logic              rot_carry;
  logic [DATA_W-1:0] rot_result;
  logic              rot_carry_out;
  logic              sub_borrow;
  logic [DATA_W-1:0] sub_diff;
  flags_t            sub_flags;

  always_comb begin
    rot_right  = (req_q.op == OP_ROTATE_RIGHT_MEM)
               | (req_q.op == OP_ROTATE_RIGHT_TO_ACC)
               | (req_q.op == OP_ROTATE_RIGHT_CARRY_MEM)
               | (req_q.op == OP_ROTATE_RIGHT_CARRY_TO_ACC);
    rot_carry  = (req_q.op == OP_ROTATE_LEFT_CARRY_MEM)
               | (req_q.op == OP_ROTATE_LEFT_CARRY_TO_ACC)
               | (req_q.op == OP_ROTATE_RIGHT_CARRY_MEM)
               | (req_q.op == OP_ROTATE_RIGHT_CARRY_TO_ACC);
    sub_borrow = (req_q.op == OP_SUBTRACT_BORROW_TO_ACC)
               | (req_q.op == OP_SUBTRACT_BORROW_TO_MEM);
  end

  byte_rotator u_rotator (
    .operand       (mem_rd_data),
    .carry_in      (flags_q.c),
    .dir_right     (rot_right),
    .through_carry (rot_carry),
    .result        (rot_result),
    .carry_out     (rot_carry_out)
  );

  byte_subtractor u_subtractor (
    .minuend    (acc_q),
    .subtrahend (mem_rd_data),
    .use_borrow (sub_borrow),
    .flags_in   (flags_q),
    .diff       (sub_diff),
    .flags_out  (sub_flags)
  );

  // ****************************************
  // Result selection
  // ****************************************
  // Eight-bit datapath throughout
  logic [DATA_W-1:0] next_result;
  logic              next_to_mem;
  logic              next_to_acc;
  logic              next_flags_en;
  flags_t            next_flags;

  always_comb begin
    next_result   = BYTE_ZERO;
    next_to_mem   = 1'b0;
    next_to_acc   = 1'b0;
    next_flags_en = 1'b0;
    next_flags    = flags_q;
    next_skip     = 1'b0;
    case (req_q.op)
      OP_ROTATE_LEFT_MEM, OP_ROTATE_RIGHT_MEM: begin
        next_result = rot_result;
        next_to_mem = 1'b1;
      end
      OP_ROTATE_LEFT_TO_ACC, OP_ROTATE_RIGHT_TO_ACC: begin
        next_result = rot_result;
        next_to_acc = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY_MEM, OP_ROTATE_RIGHT_CARRY_MEM: begin
        next_result   = rot_result;
        next_to_mem   = 1'b1;
        next_flags_en = 1'b1;
        next_flags.c  = rot_carry_out;
      end
      OP_ROTATE_LEFT_CARRY_TO_ACC, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        next_result   = rot_result;
        next_to_acc   = 1'b1;
        next_flags_en = 1'b1;
        next_flags.c  = rot_carry_out;
      end
      OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_TO_ACC: begin
        next_result   = sub_diff;
        next_to_acc   = 1'b1;
        next_flags_en = 1'b1;
        next_flags    = sub_flags;
      end
      OP_SUBTRACT_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM: begin
        next_result   = sub_diff;
        next_to_mem   = 1'b1;
        next_flags_en = 1'b1;
        next_flags    = sub_flags;
      end
      OP_DECREMENT_SKIP_ZERO: begin
        next_result = mem_rd_data - BYTE_ONE;
        next_to_mem = 1'b1;
        next_skip   = (next_result == BYTE_ZERO);
      end
      OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
        next_result = mem_rd_data - BYTE_ONE;
        next_to_acc = 1'b1;
        next_skip   = (next_result == BYTE_ZERO);
      end
      OP_INCREMENT_SKIP_ZERO: begin
        next_result = mem_rd_data + BYTE_ONE;
        next_to_mem = 1'b1;
        next_skip   = (next_result == BYTE_ZERO);
      end
      OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
        next_result = mem_rd_data + BYTE_ONE;
        next_to_acc = 1'b1;
        next_skip   = (next_result == BYTE_ZERO);
      end
      OP_SET_BYTE: begin
        next_result = BYTE_ALL_ONES;
        next_to_mem = 1'b1;
      end
      OP_SET_BIT: begin
        next_result = mem_rd_data | (BYTE_ONE << req_q.bit_sel);
        next_to_mem = 1'b1;
      end
      OP_SKIP_IF_NONZERO_BYTE: begin
        next_skip = (mem_rd_data != BYTE_ZERO);
      end
      OP_SKIP_IF_NONZERO_BIT: begin
        next_skip = mem_rd_data[req_q.bit_sel];
      end
      OP_NIBBLE_SWAP_MEM: begin
        next_result = {mem_rd_data[NIBBLE_W-1:0],
                       mem_rd_data[DATA_W-1:NIBBLE_W]};
        next_to_mem = 1'b1;
      end
      OP_NIBBLE_SWAP_TO_ACC: begin
        next_result = {mem_rd_data[NIBBLE_W-1:0],
                       mem_rd_data[DATA_W-1:NIBBLE_W]};
        next_to_acc = 1'b1;
      end
      default: begin
        next_result = BYTE_ZERO;
      end
    endcase
    if (state != ST_EXEC) begin
      next_skip = 1'b0;
    end
  end

  // ****************************************
  // Memory port
  // ****************************************
  // Address held from start to write-back; no section bits to split
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr <= ADDR_RESET;
    end else if (start && state == ST_IDLE) begin
      mem_addr <= request.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rd_en <= 1'b0;
    end else begin
      mem_rd_en <= start && state == ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_wr_en   <= 1'b0;
      mem_wr_data <= BYTE_ZERO;
    end else begin
      mem_wr_en   <= (state == ST_EXEC) && next_to_mem;
      mem_wr_data <= next_result;
    end
  end

  // ****************************************
  // Accumulator and flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_wr_en   <= 1'b0;
      acc_wr_data <= BYTE_ZERO;
    end else begin
      acc_wr_en   <= (state == ST_EXEC) && next_to_acc;
      acc_wr_data <= next_result;
    end
  end

  // Untouched flags are written back as captured, so a full-word write is safe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_wr_en <= 1'b0;
      flags_wr    <= FLAGS_RESET;
    end else begin
      flags_wr_en <= (state == ST_EXEC) && next_flags_en;
      flags_wr    <= next_flags;
    end
  end

  // ****************************************
  // Completion and skip
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skip_next  <= 1'b0;
      dummy_slot <= 1'b0;
      done       <= 1'b0;
      busy       <= 1'b0;
    end else begin
      skip_next  <= next_skip;
      dummy_slot <= (state == ST_DUMMY);
      done       <= (next_state == ST_IDLE) && (state != ST_IDLE);
      busy       <= (next_state != ST_IDLE);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  rotate_left_a: assert property (@(posedge clk)
    mem_wr_en && req_q.op == OP_ROTATE_LEFT_MEM |->
      mem_wr_data == {operand_q[DATA_W-2:0], operand_q[DATA_W-1]})
    else $error("rotate left result wrong");
  acc_rotate_a: assert property (@(posedge clk)
    $rose(acc_wr_en) && req_q.op inside {OP_ROTATE_LEFT_TO_ACC,
      OP_ROTATE_RIGHT_TO_ACC, OP_ROTATE_LEFT_CARRY_TO_ACC,
      OP_ROTATE_RIGHT_CARRY_TO_ACC} |-> !mem_wr_en)
    else $error("accumulator rotate wrote memory");
  carry_rotate_a: assert property (@(posedge clk)
    flags_wr_en && req_q.op == OP_ROTATE_RIGHT_CARRY_MEM |->
      flags_wr.c == operand_q[0]
      && mem_wr_data[DATA_W-1] == flags_q.c)
    else $error("rotate right through carry wrong");
  sub_carry_a: assert property (@(posedge clk)
    flags_wr_en && req_q.op == OP_SUBTRACT_TO_ACC |->
      flags_wr.c == (acc_q >= operand_q))
    else $error("subtract carry wrong");
  sub_mem_a: assert property (@(posedge clk)
    mem_wr_en && req_q.op == OP_SUBTRACT_BORROW_TO_MEM |->
      mem_wr_data == DATA_W'(acc_q - operand_q - {7'h00, ~flags_q.c})
      && !acc_wr_en)
    else $error("borrow subtract to memory wrong");
  dec_skip_a: assert property (@(posedge clk)
    mem_wr_en && req_q.op == OP_DECREMENT_SKIP_ZERO |->
      skip_next == (operand_q == BYTE_ONE) && !flags_wr_en)
    else $error("decrement skip wrong");
  skip_dummy_a: assert property (@(posedge clk)
    skip_next |-> !done ##1 (dummy_slot && done))
    else $error("skip dummy cycle missing");
  start_fetch_a: assert property (@(posedge clk)
    start && !busy |=> mem_rd_en && mem_addr == $past(request.addr)
      ##1 !mem_rd_en ##1 (done || skip_next))
    else $error("fetch timing wrong");
  set_bit_a: assert property (@(posedge clk)
    mem_wr_en && req_q.op == OP_SET_BIT |->
      mem_wr_data[req_q.bit_sel]
      && (mem_wr_data & ~(BYTE_ONE << req_q.bit_sel))
         == (operand_q & ~(BYTE_ONE << req_q.bit_sel)))
    else $error("bit set wrong");
  swap_a: assert property (@(posedge clk)
    mem_wr_en && req_q.op == OP_NIBBLE_SWAP_MEM |->
      mem_wr_data == {operand_q[NIBBLE_W-1:0], operand_q[DATA_W-1:NIBBLE_W]}
      && !flags_wr_en)
    else $error("nibble swap wrong");

endmodule

// ---- tb/byte_mem_model.sv ----
`timescale 1ns/1ps
module byte_mem_model
  import ext_byte_op_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [DATA_W-1:0] rd_data
);
  // ****************************************
  // Flat byte store
  // ****************************************
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_q = 8'h5a;

  assign rd_data = rd_q;

  // Valid only the cycle after a read; toggles otherwise, no stale match
  always @(posedge clk) begin
    if (rd_en) begin
      rd_q <= mem[addr];
    end else begin
      rd_q <= ~rd_q;
    end
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end
endmodule

// ---- tb/extended_byte_op_datapath_tb.sv ----
`timescale 1ns/1ps
module extended_byte_op_datapath_tb;
  import ext_byte_op_pkg::*;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              start = 1'b0;
  request_t          request = REQUEST_RESET;
  logic [DATA_W-1:0] accumulator_in = 8'h00;
  flags_t            flags_in = FLAGS_RESET;
  logic [DATA_W-1:0] mem_rd_data;
  logic              busy, mem_rd_en, mem_wr_en, acc_wr_en;
  logic              flags_wr_en, skip_next, dummy_slot, done;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wr_data, acc_wr_data;
  flags_t            flags_wr;
  int                failures = 0;
  int                cmp_count = 0;

  always #10 clk = ~clk;

  extended_byte_op_datapath i_extended_byte_op_datapath (
    .clk(clk), .rst_n(rst_n), .start(start), .request(request),
    .accumulator_in(accumulator_in), .flags_in(flags_in),
    .mem_rd_data(mem_rd_data), .busy(busy), .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
    .flags_wr_en(flags_wr_en), .flags_wr(flags_wr), .skip_next(skip_next),
    .dummy_slot(dummy_slot), .done(done));

  byte_mem_model i_byte_mem_model (
    .clk(clk), .rd_en(mem_rd_en), .addr(mem_addr), .wr_en(mem_wr_en),
    .wr_data(mem_wr_data), .rd_data(mem_rd_data));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One operation; outputs sampled mid-cycle so edge updates have landed
  task automatic do_op(input op_t op, input logic [11:0] a,
    input logic [2:0] b, input logic [7:0] acc, input flags_t fl,
    input logic [7:0] m, input logic [7:0] ex_m, input logic ex_aw,
    input logic [7:0] ex_acc, input logic ex_fw, input flags_t ex_fl,
    input logic ex_sk);
    logic       aw, fw, sk, dm;
    logic [7:0] ad;
    flags_t     fd;
    int         n_done;
    aw = 0; fw = 0; sk = 0; dm = 0; ad = '0; fd = '0; n_done = 0;
    i_byte_mem_model.mem[a] = m;
    @(posedge clk);
    start <= 1'b1;
    request <= '{op: op, addr: a, bit_sel: b};
    accumulator_in <= acc;
    flags_in <= fl;
    for (int n = 1; n <= 8 && n_done == 0; n++) begin
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      if (n == 1) check("address", 16'(mem_addr), 16'(a));
      if (acc_wr_en === 1'b1) begin
        aw = 1;
        ad = acc_wr_data;
      end
      if (flags_wr_en === 1'b1) begin
        fw = 1;
        fd = flags_wr;
      end
      if (skip_next === 1'b1) sk = 1;
      if (dummy_slot === 1'b1) dm = 1;
      if (done === 1'b1) n_done = n;
    end
    @(posedge clk);
    #1;
    check("memory", 16'(i_byte_mem_model.mem[a]), 16'(ex_m));
    check("acc write", 16'(aw), 16'(ex_aw));
    if (ex_aw) check("acc data", 16'(ad), 16'(ex_acc));
    check("flag write", 16'(fw), 16'(ex_fw));
    if (ex_fw) check("flags", 16'(fd), 16'(ex_fl));
    check("skip", 16'(sk), 16'(ex_sk));
    check("dummy", 16'(dm), 16'(ex_sk));
    check("done cycle", 16'(n_done), 16'(3 + ex_sk));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_rotate();
    logic [7:0] m, r;
    flags_t     fl, ef;
    logic       right, thru, to_acc;
    m = 8'h68;
    fl = 6'b101110;
    for (int i = 0; i < 8; i++) begin
      right = i[2];
      thru = i[1];
      to_acc = i[0];
      ef = fl;
      if (right) r = {thru ? fl.c : m[0], m[7:1]};
      else r = {m[6:0], thru ? fl.c : m[7]};
      if (thru) ef.c = right ? m[0] : m[7];
      do_op(op_t'(i), 12'hfa5, 3'h0, 8'h11, fl, m, to_acc ? m : r,
            to_acc, r, thru, ef, 1'b0);
    end
    $display("test rotate finished");
  endtask

  task automatic test_subtract();
    logic [7:0] ta [4] = '{8'h50, 8'h30, 8'h80, 8'h10};
    logic [7:0] tm [4] = '{8'h30, 8'h50, 8'h01, 8'h0f};
    logic [7:0] a, m, r;
    logic [8:0] d9;
    logic [4:0] h5;
    logic       bw, bop;
    flags_t     fl, ef;
    for (int k = 0; k < 4; k++) begin
      for (int o = 0; o < 4; o++) begin
        a = ta[k];
        m = tm[k];
        fl = (k == 0) ? 6'b000101 : (k == 3) ? 6'b000000 : 6'b000001;
        bop = (o < 2);
        bw = bop & ~fl.c;
        d9 = {1'b0, a} - {1'b0, m} - 9'(bw);
        h5 = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(bw);
        r = d9[7:0];
        ef.c = ~d9[8];
        ef.z = (r == 8'h00);
        ef.ac = ~h5[4];
        ef.ov = (a[7] != m[7]) && (r[7] != a[7]);
        ef.sc = ef.ov ^ r[7];
        ef.cz = bop ? (ef.z & fl.cz) : ef.z;
        do_op(op_t'(8 + o), 12'h3c7, 3'h0, a, fl, m, o[0] ? r : m,
              ~o[0], r, 1'b1, ef, 1'b0);
      end
    end
    $display("test subtract finished");
  endtask

  task automatic test_step_skip();
    logic [7:0] ms [3] = '{8'h01, 8'hff, 8'h00};
    logic [7:0] m, r;
    flags_t     fl;
    fl = 6'b110011;
    for (int k = 0; k < 3; k++) begin
      for (int o = 0; o < 4; o++) begin
        m = ms[k];
        r = o[1] ? m + 8'h01 : m - 8'h01;
        do_op(op_t'(12 + o), 12'h800, 3'h0, 8'h77, fl, m, o[0] ? m : r,
              o[0], r, 1'b0, fl, r == 8'h00);
      end
    end
    $display("test step skip finished");
  endtask

  task automatic test_set_swap();
    flags_t fl;
    fl = 6'b010101;
    do_op(OP_SET_BYTE, 12'h001, 3'h0, 8'h00, fl, 8'h5a, 8'hff, 1'b0,
          8'h00, 1'b0, fl, 1'b0);
    for (int b = 0; b < 8; b++) begin
      do_op(OP_SET_BIT, 12'h002, 3'(b), 8'h00, fl, 8'h5a,
            8'h5a | (8'h01 << b), 1'b0, 8'h00, 1'b0, fl, 1'b0);
    end
    do_op(OP_NIBBLE_SWAP_MEM, 12'hffe, 3'h0, 8'h00, fl, 8'h3c, 8'hc3,
          1'b0, 8'h00, 1'b0, fl, 1'b0);
    do_op(OP_NIBBLE_SWAP_TO_ACC, 12'hffe, 3'h0, 8'h00, fl, 8'h3c, 8'h3c,
          1'b1, 8'hc3, 1'b0, fl, 1'b0);
    $display("test set swap finished");
  endtask

  task automatic test_skip_nonzero();
    flags_t fl;
    fl = 6'b101010;
    do_op(OP_SKIP_IF_NONZERO_BYTE, 12'h7ff, 3'h0, 8'h00, fl, 8'h00, 8'h00,
          1'b0, 8'h00, 1'b0, fl, 1'b0);
    do_op(OP_SKIP_IF_NONZERO_BYTE, 12'h7ff, 3'h0, 8'h00, fl, 8'h80, 8'h80,
          1'b0, 8'h00, 1'b0, fl, 1'b1);
    for (int b = 0; b < 8; b++) begin
      do_op(OP_SKIP_IF_NONZERO_BIT, 12'h400, 3'(b), 8'h00, fl, 8'h5a, 8'h5a,
            1'b0, 8'h00, 1'b0, fl, 1'((8'h5a >> b) & 8'h01));
    end
    $display("test skip nonzero finished");
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("idle", 16'({busy, done, mem_wr_en, acc_wr_en}), 16'h0);
    test_rotate();
    test_subtract();
    test_step_skip();
    test_set_swap();
    test_skip_nonzero();
    stop_test();
  end

  // About 60 operations of under 12 cycles each
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
